//--- core/tws_params.svh
// Purpose: Timing and address constants of the two-wire register port
// Assumes: 125 MHz system clock on both ends
// Notes:   Counts are derived from times, never typed in as cycles
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

`define TWS_CLK_NS      8
`define TWS_BIT_NS      10000
// Quarter bit period, rounded up so the rate never passes 100 kbit/s
`define TWS_QTR_CYC     ((`TWS_BIT_NS / 4 + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_QTR_W       9
`define TWS_BASE_LO     7'h44
`define TWS_BASE_HI     7'h45
`define TWS_SWRST_PTR   8'h1f
`define TWS_PTR_RST     8'h00
`define TWS_LAST_BIT    3'h7
`define TWS_ACK_BIT     4'h8

`endif

//--- core/tws_pkg.sv
// Purpose: Types shared by both ends of the two-wire register port
// Assumes: Nothing beyond the params header
// Notes:   States carry no codes on purpose
`default_nettype none

package tws_pkg;

  typedef enum logic [1:0] {
    TWS_CMD_START,
    TWS_CMD_STOP,
    TWS_CMD_WRITE,
    TWS_CMD_READ
  } tws_cmd_e;

  typedef enum logic [2:0] {
    TWS_S_IDLE,
    TWS_S_ADDR,
    TWS_S_ACK,
    TWS_S_WR,
    TWS_S_RD,
    TWS_S_RACK,
    TWS_S_RNEXT
  } tws_sst_e;

  typedef enum logic [1:0] {
    TWS_M_IDLE,
    TWS_M_START,
    TWS_M_STOP,
    TWS_M_BITS
  } tws_mst_e;

endpackage : tws_pkg

`default_nettype wire

//--- core/tws_if.sv
// Purpose: Open-drain two-wire link joining master and slave
// Assumes: Pull-ups on both lines; an enable high pulls the line low
// Notes:   Wire levels are resolved here, not in either end
`default_nettype none

interface tws_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  assign scl = !(scl_oe && !scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport host (
    output scl_o, scl_oe, m_sda_o, m_sda_oe,
    input  scl, sda
  );

  modport dev (
    output s_sda_o, s_sda_oe,
    input  scl, sda
  );
endinterface : tws_if

`default_nettype wire

//--- core/tws_slave.sv
// Purpose: Slave end of the two-wire port giving access to 8-bit control registers
// Assumes: Master keeps the bus at or below 100 kbit/s; lines arrive asynchronously
// Notes:   Never drives SCL; SDA is only ever pulled low or released
//
// Functional notes
// - Bit rate at most 100 kbit/s.
// - Slave only; never drives clock or conditions.
// - SDA falling while SCL high is start.
// - SDA rising while SCL high is stop.
// - Master starts only at cycle or byte boundaries.
// - Stop anywhere abandons the current transfer.
// - SDA stays stable while SCL is high.
// - Address 1000100 or 1000101 by select input.
// - Address MSB first; acknowledge on match.
// - Master releases SDA, samples acknowledge on rise.
// - Master stops when address not acknowledged.
// - First written byte loads register pointer.
// - Later bytes write register, pointer increments.
// - Reads shift pointed register MSB first, increment.
// - Master nack ends read; slave releases SDA.
// - Master ack continues with next register.
// - Reads begin at the current pointer value.
// - Repeated start begins a new address phase.
// - Write to pointer 0x1F restores register defaults.
`default_nettype none
`include "tws_params.svh"

module tws_slave
  import tws_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  tws_if.dev              bus,
  input  wire logic       bus_address_select,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_we,
  output logic            ctrl_defaults
);

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] sel_sync_q;
  logic       scl_d1_q;
  logic       sda_d1_q;
  tws_sst_e   state_q;
  logic [2:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic       ptr_set_q;
  logic       read_q;
  logic       sda_oe_q;
  logic       sda_o_q;
  logic [7:0] reg_addr_q;
  logic [7:0] reg_wdata_q;
  logic       reg_we_q;
  logic       defaults_q;

  wire        scl_s     = scl_sync_q[1];
  wire        sda_s     = sda_sync_q[1];
  wire        scl_rise  = scl_s && !scl_d1_q;
  wire        scl_fall  = !scl_s && scl_d1_q;
  wire        start_det = scl_s && scl_d1_q && sda_d1_q && !sda_s;
  wire        stop_det  = scl_s && scl_d1_q && !sda_d1_q && sda_s;
  wire [7:0]  byte_in   = {shift_q[6:0], sda_s};
  wire        last_bit  = (cnt_q == `TWS_LAST_BIT);
  wire [6:0]  own_base  = sel_sync_q[1] ? `TWS_BASE_HI : `TWS_BASE_LO;
  wire        addr_hit  = (byte_in[7:1] == own_base);
  wire        swrst_hit = (ptr_q == `TWS_SWRST_PTR);

  assign bus.s_sda_o   = sda_o_q;
  assign bus.s_sda_oe  = sda_oe_q;
  assign reg_addr      = reg_addr_q;
  assign reg_wdata     = reg_wdata_q;
  assign reg_we        = reg_we_q;
  assign ctrl_defaults = defaults_q;

  // Pins and the select strap pass two flops before use
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      sel_sync_q <= 2'h0;
      scl_d1_q   <= 1'b1;
      sda_d1_q   <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      sel_sync_q <= {sel_sync_q[0], bus_address_select};
      scl_d1_q   <= scl_s;
      sda_d1_q   <= sda_s;
    end
  end

  // Address lags the pointer by a cycle so a write strobe sees the old value
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_addr_q <= `TWS_PTR_RST;
      sda_o_q    <= 1'b0;
    end else begin
      reg_addr_q <= ptr_q;
      sda_o_q    <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= TWS_S_IDLE;
      cnt_q       <= 3'h0;
      shift_q     <= 8'h00;
      ptr_q       <= `TWS_PTR_RST;
      ptr_set_q   <= 1'b0;
      read_q      <= 1'b0;
      sda_oe_q    <= 1'b0;
      reg_wdata_q <= 8'h00;
      reg_we_q    <= 1'b0;
      defaults_q  <= 1'b0;
    end else begin
      reg_we_q   <= 1'b0;
      defaults_q <= 1'b0;
      if (stop_det) begin
        state_q  <= TWS_S_IDLE;
        sda_oe_q <= 1'b0;
      end else if (start_det) begin
        state_q  <= TWS_S_ADDR;
        cnt_q    <= 3'h0;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (state_q)
          TWS_S_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          TWS_S_ADDR: begin
            if (scl_rise) begin
              shift_q <= byte_in;
              cnt_q   <= cnt_q + 3'h1;
              if (last_bit) begin
                read_q    <= byte_in[0];
                ptr_set_q <= 1'b0;
                state_q   <= addr_hit ? TWS_S_ACK : TWS_S_IDLE;
              end
            end
          end
          TWS_S_ACK: begin
            // SDA only changes after SCL falls
            if (scl_fall) begin
              if (!sda_oe_q) begin
                sda_oe_q <= 1'b1;
              end else if (read_q) begin
                shift_q  <= reg_rdata;
                sda_oe_q <= !reg_rdata[7];
                cnt_q    <= 3'h0;
                state_q  <= TWS_S_RD;
              end else begin
                sda_oe_q <= 1'b0;
                cnt_q    <= 3'h0;
                state_q  <= TWS_S_WR;
              end
            end
          end
          TWS_S_WR: begin
            if (scl_rise) begin
              shift_q <= byte_in;
              cnt_q   <= cnt_q + 3'h1;
              if (last_bit) begin
                state_q <= TWS_S_ACK;
                if (!ptr_set_q) begin
                  ptr_q     <= byte_in;
                  ptr_set_q <= 1'b1;
                end else begin
                  reg_we_q    <= 1'b1;
                  reg_wdata_q <= byte_in;
                  ptr_q       <= ptr_q + 8'h01;
                  defaults_q  <= swrst_hit;
                end
              end
            end
          end
          TWS_S_RD: begin
            if (scl_fall) begin
              if (last_bit) begin
                sda_oe_q <= 1'b0;
                ptr_q    <= ptr_q + 8'h01;
                state_q  <= TWS_S_RACK;
              end else begin
                shift_q  <= {shift_q[6:0], 1'b0};
                sda_oe_q <= !shift_q[6];
                cnt_q    <= cnt_q + 3'h1;
              end
            end
          end
          TWS_S_RACK: begin
            if (scl_rise) begin
              state_q <= sda_s ? TWS_S_IDLE : TWS_S_RNEXT;
            end
          end
          TWS_S_RNEXT: begin
            if (scl_fall) begin
              shift_q  <= reg_rdata;
              sda_oe_q <= !reg_rdata[7];
              cnt_q    <= 3'h0;
              state_q  <= TWS_S_RD;
            end
          end
          default: begin
            state_q  <= TWS_S_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : tws_slave

`default_nettype wire

//--- core/tws_master.sv
// Purpose: Master end of the two-wire port, one bus operation per command
// Assumes: Caller orders commands as a legal transfer
// Notes:   No clock stretching; SCL is timed only by the divider
`default_nettype none
`include "tws_params.svh"

module tws_master
  import tws_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  tws_if.host             bus,
  input  wire logic       cmd_valid,
  input  wire tws_cmd_e   cmd_kind,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_ack,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic      [7:0] rsp_data,
  output logic            rsp_nack
);

  localparam logic [`TWS_QTR_W-1:0] QTR_LAST = `TWS_QTR_W'(`TWS_QTR_CYC - 1);

  logic [1:0]            sda_sync_q;
  tws_mst_e              state_q;
  logic [`TWS_QTR_W-1:0] qtr_q;
  logic [1:0]            ph_q;
  logic [3:0]            bit_q;
  logic [8:0]            out_q;
  logic [8:0]            rx_q;
  logic                  scl_oe_q;
  logic                  sda_oe_q;
  logic                  ready_q;
  logic                  rsp_valid_q;
  logic [7:0]            rsp_data_q;
  logic                  rsp_nack_q;

  wire       accept  = cmd_valid && ready_q;
  wire       tick    = (state_q != TWS_M_IDLE) && (qtr_q == QTR_LAST);
  wire       is_bits = (state_q == TWS_M_BITS);
  wire       finish  = tick && (ph_q == 2'h3) && (!is_bits || bit_q == `TWS_ACK_BIT);
  // release SDA for the slave's acknowledge
  wire [8:0] wr_bits = {cmd_data, 1'b1};
  wire [8:0] rd_bits = {8'hff, !cmd_ack};
  wire [8:0] load    = (cmd_kind == TWS_CMD_READ) ? rd_bits : wr_bits;

  assign bus.scl_o    = 1'b0;
  assign bus.m_sda_o  = 1'b0;
  assign bus.scl_oe   = scl_oe_q;
  assign bus.m_sda_oe = sda_oe_q;
  assign cmd_ready    = ready_q;
  assign rsp_valid    = rsp_valid_q;
  assign rsp_data     = rsp_data_q;
  assign rsp_nack     = rsp_nack_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sda_sync_q <= 2'h3;
    end else begin
      sda_sync_q <= {sda_sync_q[0], bus.sda};
    end
  end

  always_ff @(posedge clk) begin
    if (rst || accept || tick) begin
      qtr_q <= '0;
    end else if (state_q != TWS_M_IDLE) begin
      qtr_q <= qtr_q + `TWS_QTR_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= TWS_M_IDLE;
      ph_q        <= 2'h0;
      bit_q       <= 4'h0;
      out_q       <= 9'h1ff;
      rx_q        <= 9'h000;
      scl_oe_q    <= 1'b0;
      sda_oe_q    <= 1'b0;
      ready_q     <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
      rsp_nack_q  <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (accept) begin
        ready_q <= 1'b0;
        ph_q    <= 2'h0;
        bit_q   <= 4'h0;
        out_q   <= load;
        unique case (cmd_kind)
          TWS_CMD_START: begin
            state_q  <= TWS_M_START;
            sda_oe_q <= 1'b0;
          end
          TWS_CMD_STOP: begin
            state_q  <= TWS_M_STOP;
            sda_oe_q <= 1'b1;
          end
          TWS_CMD_WRITE,
          TWS_CMD_READ: begin
            state_q  <= TWS_M_BITS;
            sda_oe_q <= !load[8];
          end
        endcase
      end else if (finish) begin
        state_q     <= TWS_M_IDLE;
        ready_q     <= 1'b1;
        rsp_valid_q <= 1'b1;
        rsp_data_q  <= rx_q[8:1];
        rsp_nack_q  <= rx_q[0];
        // caller follows a nack with a stop
      end else if (tick) begin
        ph_q <= ph_q + 2'h1;
        unique case (state_q)
          TWS_M_START: begin
            if (ph_q == 2'h0) scl_oe_q <= 1'b0;
            if (ph_q == 2'h1) sda_oe_q <= 1'b1;
            if (ph_q == 2'h2) scl_oe_q <= 1'b1;
          end
          TWS_M_STOP: begin
            if (ph_q == 2'h0) scl_oe_q <= 1'b0;
            if (ph_q == 2'h1) sda_oe_q <= 1'b0;
          end
          TWS_M_BITS: begin
            // data changes only with SCL low
            if (ph_q == 2'h0) scl_oe_q <= 1'b0;
            if (ph_q == 2'h1) rx_q     <= {rx_q[7:0], sda_sync_q[1]};
            if (ph_q == 2'h2) scl_oe_q <= 1'b1;
            if (ph_q == 2'h3) begin
              bit_q    <= bit_q + 4'h1;
              out_q    <= {out_q[7:0], 1'b1};
              sda_oe_q <= !out_q[7];
            end
          end
          TWS_M_IDLE: begin
            state_q <= TWS_M_IDLE;
          end
        endcase
      end
    end
  end

endmodule : tws_master

`default_nettype wire

//--- tb/tws_properties.sv
// Purpose: Concurrent checks on the shared two-wire link
// Assumes: Both ends on one clock, synchronous reset
// Notes:   Bit period is counted in helper logic
`default_nettype none

module tws_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // 100 kbit/s at 8 ns is 1250 clocks a bit
  localparam int MIN_BIT = 1249;
  logic        scl_q;
  logic [10:0] bit_cnt_q;
  logic [10:0] bit_cnt_d;
  wire         scl_rise;

  assign scl_rise  = scl && !scl_q;
  assign bit_cnt_d = scl_rise ? 11'h000 : bit_cnt_q + {10'h000, bit_cnt_q != 11'h7ff};

  always_ff @(posedge clk) begin
    scl_q     <= rst ? 1'b1 : scl;
    bit_cnt_q <= rst ? 11'h000 : bit_cnt_d;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence

  property p_open_drain;
    s_sda_o == 1'b0;
  endproperty
  property p_slave_hold;
    scl && $past(scl) |-> $stable(s_sda_oe);
  endproperty
  property p_drive_low;
    $rose(s_sda_oe) |-> !scl;
  endproperty
  // Both ends may pull low across a handover, but only while SCL is low
  property p_no_clash;
    scl && s_sda_oe |-> !m_sda_oe;
  endproperty
  property p_stop_idle;
    s_stop |-> !s_sda_oe [*8];
  endproperty
  property p_start_free;
    s_start |-> !s_sda_oe;
  endproperty
  property p_bit_rate;
    scl_rise |-> bit_cnt_q >= MIN_BIT;
  endproperty
  property p_low_phase;
    $fell(scl) |-> !scl [*8];
  endproperty

  a_open_drain: assert property (p_open_drain) else $error("slave drove sda high");
  a_slave_hold: assert property (p_slave_hold) else $error("slave moved sda in scl high");
  a_drive_low: assert property (p_drive_low) else $error("slave pulled sda in scl high");
  a_no_clash: assert property (p_no_clash) else $error("both ends pulled sda");
  a_stop_idle: assert property (p_stop_idle) else $error("slave pulled sda after stop");
  a_start_free: assert property (p_start_free) else $error("slave pulled sda at start");
  a_bit_rate: assert property (p_bit_rate) else $error("scl period too short");
  a_low_phase: assert property (p_low_phase) else $error("scl low phase too short");

endmodule : tws_properties

`default_nettype wire

//--- tb/tb_two_wire_register_slave.sv
// Purpose: Both ends joined; pointer write, chained read, address miss
// Assumes: One 125 MHz clock for both ends
// Notes:   Seven bytes only, each one costs about 11k clocks
`default_nettype none

module tb_two_wire_register_slave
  import tws_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk, rst, sel, cmd_valid, cmd_ack;
  logic       cmd_ready, rsp_valid, rsp_nack, reg_we, ctrl_defaults;
  tws_cmd_e   cmd_kind;
  logic [7:0] cmd_data, rsp_data, reg_addr, reg_wdata, reg_rdata, wr_data;
  logic [7:0] mem [256];
  logic [7:0] exp_q [$];
  int         error_cnt, tests_run, cyc, we_cnt, exp_ptr;
  integer     seed;

  tws_if bus ();

  assign reg_rdata = mem[reg_addr];

  tws_slave i_tws_slave (
    .clk(clk), .rst(rst), .bus(bus), .bus_address_select(sel), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .ctrl_defaults(ctrl_defaults)
  );
  tws_master i_tws_master (
    .clk(clk), .rst(rst), .bus(bus), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack)
  );
  tws_properties i_tws_properties (
    .clk(clk), .rst(rst), .scl(bus.scl), .sda(bus.sda), .m_sda_oe(bus.m_sda_oe),
    .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Called at a rising edge; returns at the edge that shows rsp_valid
  task automatic cmd(input tws_cmd_e k, input logic [7:0] d, input logic a);
    int n;
    cmd_valid <= 1'b1;
    cmd_kind  <= k;
    cmd_data  <= d;
    cmd_ack   <= a;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n == 1) chk("cmd_busy", {7'h00, cmd_ready}, 8'h00);
    end while (rsp_valid !== 1'b1 && n < 12000);
    chk("rsp_valid", {7'h00, rsp_valid}, 8'h01);
    chk("cmd_ready", {7'h00, cmd_ready}, 8'h01);
  endtask : cmd

  // Register file side: pointer model follows every strobe
  always @(posedge clk) begin
    if (reg_we === 1'b1) begin
      we_cnt++;
      chk("reg_addr", reg_addr, exp_ptr[7:0]);
      chk("reg_wdata", reg_wdata, exp_q.pop_front());
      chk("ctrl_defaults", {7'h00, ctrl_defaults}, {7'h00, exp_ptr == 'h1f});
      mem[reg_addr] = reg_wdata;
      exp_ptr++;
    end
  end

  // Ceiling covers seven bytes plus conditions with margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 98000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    seed = 32'h65cc;
    rst = 1'b1;
    sel = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = TWS_CMD_START;
    cmd_data = 8'h00;
    cmd_ack = 1'b0;
    cyc = 0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = $random(seed);
    end
    wr_data = $random(seed);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmd(TWS_CMD_START, 8'h00, 1'b0);
    cmd(TWS_CMD_WRITE, 8'h88, 1'b0);
    chk("addr_nack", {7'h00, rsp_nack}, 8'h00);
    cmd(TWS_CMD_WRITE, 8'h1f, 1'b0);
    chk("ptr_nack", {7'h00, rsp_nack}, 8'h00);
    chk("ptr_no_we", we_cnt[7:0], 8'h00);
    exp_ptr = 'h1f;
    exp_q.push_back(wr_data);
    cmd(TWS_CMD_WRITE, wr_data, 1'b0);
    chk("data_nack", {7'h00, rsp_nack}, 8'h00);
    chk("data_echo", rsp_data, wr_data);
    // repeated start only after a whole byte
    cmd(TWS_CMD_START, 8'h00, 1'b0);
    cmd(TWS_CMD_WRITE, 8'h89, 1'b0);
    chk("rd_addr_nack", {7'h00, rsp_nack}, 8'h00);
    cmd(TWS_CMD_READ, 8'h00, 1'b1);
    chk("rd_first", rsp_data, mem[exp_ptr[7:0]]);
    chk("rd_ack", {7'h00, rsp_nack}, 8'h00);
    exp_ptr++;
    cmd(TWS_CMD_READ, 8'h00, 1'b0);
    chk("rd_next", rsp_data, mem[exp_ptr[7:0]]);
    chk("rd_nack", {7'h00, rsp_nack}, 8'h01);
    cmd(TWS_CMD_STOP, 8'h00, 1'b0);
    // Strap moved: old base must now be ignored
    sel <= 1'b1;
    cmd(TWS_CMD_START, 8'h00, 1'b0);
    cmd(TWS_CMD_WRITE, 8'h88, 1'b0);
    chk("miss_nack", {7'h00, rsp_nack}, 8'h01);
    // no acknowledge, so the master stops
    cmd(TWS_CMD_STOP, 8'h00, 1'b0);
    chk("we_total", we_cnt[7:0], 8'h01);
    test_done();
  end

endmodule : tb_two_wire_register_slave

`default_nettype wire
